// [pkg/qosovr_pkg.sv]
// What this block does
// - Per-port read/write override registers, five force bits
// - Force high, regulation off: drive override value
// - Read override value in bits 3:0, reset 0
// - Write override value in bits 3:0, reset 0
// - Read override bits 11:8 show live read value
// - Write override bits 11:8 show live write value
// - Only secure accesses unless non-secure permitted
// - Outstanding regulation change waits for idle port
// - Control bit 21 selects normal or quiesce-high
// - Control bit 20 selects read latency/period mode
// - Control bit 16 selects write latency/period mode
// - Control bit 3 enables outstanding read regulation
// - Control bit 2 enables outstanding write regulation
// - Fully coherent ports read zero there, ignore writes
// - Control bit 1 enables read value regulation
// - Control bit 0 enables write value regulation
// - Target means latency or period by mode
//
// Package of constants for the QoS override register bank.
// Assumes one APB slave per bank, 32-bit data, word-aligned registers.
package qosovr_pkg;
    localparam int          NUM_PORTS       = 5;
    localparam int          NUM_LITE        = 3;
    localparam int          QW              = 4;
    localparam logic [11:0] REG_STRIDE      = 12'h010;
    localparam logic [3:0]  OFF_RD_FORCE    = 4'h0;
    localparam logic [3:0]  OFF_WR_FORCE    = 4'h4;
    localparam logic [3:0]  OFF_CTRL        = 4'h8;
    localparam int          FLD_VAL_LSB     = 0;
    localparam int          FLD_LIVE_LSB    = 8;
    localparam int          BIT_QUIESCE     = 21;
    localparam int          BIT_RD_PERIOD   = 20;
    localparam int          BIT_WR_PERIOD   = 16;
    localparam int          BIT_OT_RD       = 3;
    localparam int          BIT_OT_WR       = 2;
    localparam int          BIT_QV_RD       = 1;
    localparam int          BIT_QV_WR       = 0;
    localparam logic [3:0]  RST_FORCE_VAL   = 4'h0;
    localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK_LITE = 32'h0031_000f;
    localparam logic [31:0] CTRL_WMASK_COH  = 32'h0031_0003;

    typedef struct packed {
        logic [QW-1:0] rd_force;
        logic [QW-1:0] wr_force;
        logic [31:0]   ctrl;
        logic          ot_rd_act;
        logic          ot_wr_act;
    } qosovr_port_s;

    // Five-input pick of the applied QoS value
    function automatic logic [QW-1:0] qosovr_pick(input logic force_in, input logic reg_en,
                                                  input logic [QW-1:0] ovr, input logic [QW-1:0] live,
                                                  input logic [QW-1:0] master);
        if (force_in && !reg_en)
            return ovr;
        else if (force_in && reg_en && master == '0)
            return live;
        return master;
    endfunction
endpackage

// [pkg/qosovr_port_if.sv]
// Interface between the bank and one port's register slice.
// Assumes the bank decodes APB and only one slice is written at a time.
`timescale 1ns/1ps
`default_nettype none
interface qosovr_port_if;
    logic                 wr_en;
    logic [3:0]           wr_off;
    logic [31:0]          wdata;
    logic [31:0]          rd_force_q;
    logic [31:0]          wr_force_q;
    logic [31:0]          ctrl_q;
    logic                 ot_rd_act;
    logic                 ot_wr_act;
    modport bank  (output wr_en, wr_off, wdata, input rd_force_q, wr_force_q, ctrl_q, ot_rd_act, ot_wr_act);
    modport slice (input wr_en, wr_off, wdata, output rd_force_q, wr_force_q, ctrl_q, ot_rd_act, ot_wr_act);
endinterface
`default_nettype wire

// [rtl/qosovr_apb_slave.sv]
// APB slave front end: zero-wait answer, security check, port decode.
// Assumes word-aligned APB accesses with 12-bit address space.
`timescale 1ns/1ps
`default_nettype none
module qosovr_apb_slave (
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [2:0]  pprot,
    input  wire logic        nonsec_allow,
    // Decoded access
    output logic             pready,
    output logic             acc_ok,
    output logic             wr_go,
    output logic [2:0]       port_idx,
    output logic [3:0]       reg_off
);
    import qosovr_pkg::*;

    logic hit;
    logic sec_ok;

    // Address and security decode
    always_comb begin
        port_idx = paddr[6:4];
        reg_off  = paddr[3:0];
        hit      = (paddr[11:7] == 5'h00) && (paddr[6:4] < 3'(NUM_PORTS))
                   && (paddr[3:0] <= OFF_CTRL) && (paddr[1:0] == 2'b00); // Word-aligned offsets only
        sec_ok   = !pprot[1] || nonsec_allow;
        acc_ok   = hit && sec_ok;
        pready   = psel && penable;
        wr_go    = psel && penable && pwrite && acc_ok;
    end
endmodule // qosovr_apb_slave
`default_nettype wire

// [rtl/qosovr_port_regs.sv]
// Register slice for one slave port: override values and control word.
// Assumes writes arrive already checked for security and address.
`timescale 1ns/1ps
`default_nettype none
module qosovr_port_regs #(
    parameter bit IS_LITE = 1'b1
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Register access
    qosovr_port_if.slice    rif,
    // Live regulator values and port activity
    input  wire logic [3:0] live_rd,
    input  wire logic [3:0] live_wr,
    input  wire logic       rd_idle,
    input  wire logic       wr_idle
);
    import qosovr_pkg::*;

    qosovr_port_s st_ff;
    qosovr_port_s nxt_st;
    logic [31:0]  wmask;

    assign wmask = IS_LITE ? CTRL_WMASK_LITE : CTRL_WMASK_COH;

    // Next-state of the slice
    always_comb begin
        nxt_st = st_ff;
        if (rif.wr_en) begin
            case (rif.wr_off)
                OFF_RD_FORCE: nxt_st.rd_force = rif.wdata[FLD_VAL_LSB +: QW];
                OFF_WR_FORCE: nxt_st.wr_force = rif.wdata[FLD_VAL_LSB +: QW];
                OFF_CTRL:     nxt_st.ctrl = rif.wdata & wmask;
                default:      nxt_st = st_ff;
            endcase
        end
        // Outstanding regulation switches only while the channel is idle
        if (rd_idle)
            nxt_st.ot_rd_act = st_ff.ctrl[BIT_OT_RD];
        if (wr_idle)
            nxt_st.ot_wr_act = st_ff.ctrl[BIT_OT_WR];
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff.rd_force  <= RST_FORCE_VAL;
            st_ff.wr_force  <= RST_FORCE_VAL;
            st_ff.ctrl      <= RST_CTRL;
            st_ff.ot_rd_act <= 1'b0;
            st_ff.ot_wr_act <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read views; live values sit in 11:8
    assign rif.rd_force_q = {20'h0_0000, live_rd, 4'h0, st_ff.rd_force};
    assign rif.wr_force_q = {20'h0_0000, live_wr, 4'h0, st_ff.wr_force};
    assign rif.ctrl_q     = st_ff.ctrl;
    assign rif.ot_rd_act  = st_ff.ot_rd_act;
    assign rif.ot_wr_act  = st_ff.ot_wr_act;

    AST_OT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rd_idle |=> $stable(st_ff.ot_rd_act)) else $error("read OT enable changed while busy");
    AST_COH_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        !IS_LITE |-> st_ff.ctrl[BIT_OT_RD:BIT_OT_WR] == 2'b00) else $error("coherent port OT bits set");
    AST_OT_WR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_idle |=> $stable(st_ff.ot_wr_act)) else $error("write OT enable changed while busy");
endmodule // qosovr_port_regs
`default_nettype wire

// [rtl/qosovr_regs.sv]
// Top: QoS override and regulation control bank for five slave ports.
// Assumes the regulator datapath lives outside and feeds live values in.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module qosovr_regs (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [2:0]  pprot,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Security permission
    input  wire logic        nonsec_allow,
    // Force inputs, one per port
    input  wire logic [4:0]  port_qos_force_inputs,
    // Master QoS and live regulator values, 4 bits per port
    input  wire logic [19:0] master_arqos,
    input  wire logic [19:0] master_awqos,
    input  wire logic [19:0] live_arqos,
    input  wire logic [19:0] live_awqos,
    input  wire logic [4:0]  rd_idle,
    input  wire logic [4:0]  wr_idle,
    // Outputs to regulators and ports
    output logic [19:0]      out_arqos,
    output logic [19:0]      out_awqos,
    output logic [4:0]       qv_rd_en,
    output logic [4:0]       qv_wr_en,
    output logic [4:0]       rd_period_mode,
    output logic [4:0]       wr_period_mode,
    output logic [4:0]       quiesce_high,
    output logic [4:0]       ot_rd_en,
    output logic [4:0]       ot_wr_en
);
    import qosovr_pkg::*;

    logic        acc_ok;
    logic        wr_go;
    logic [2:0]  port_idx;
    logic [3:0]  reg_off;
    logic [31:0] rd_word [NUM_PORTS];

    // Captured response of the current transfer
    typedef struct packed {
        logic [31:0] rdata;
        logic        err;
    } qosovr_rsp_s;

    qosovr_rsp_s rsp_ff;
    qosovr_rsp_s nxt_rsp;

    qosovr_apb_slave u_apb (
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pprot        (pprot),
        .nonsec_allow (nonsec_allow),
        .pready       (pready),
        .acc_ok       (acc_ok),
        .wr_go        (wr_go),
        .port_idx     (port_idx),
        .reg_off      (reg_off)
    );

    // One slice per port; ports 3 and 4 are fully coherent
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        qosovr_port_if pif ();
        assign pif.wr_en  = wr_go && (port_idx == 3'(p));
        assign pif.wr_off = reg_off;
        assign pif.wdata  = pwdata;

        qosovr_port_regs #(.IS_LITE(p < NUM_LITE)) u_slice (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .rif      (pif),
            .live_rd  (live_arqos[p*QW +: QW]),
            .live_wr  (live_awqos[p*QW +: QW]),
            .rd_idle  (rd_idle[p]),
            .wr_idle  (wr_idle[p])
        );

        // Mode and enable outputs toward the regulator
        assign qv_rd_en[p]       = pif.ctrl_q[BIT_QV_RD];
        assign qv_wr_en[p]       = pif.ctrl_q[BIT_QV_WR];
        assign rd_period_mode[p] = pif.ctrl_q[BIT_RD_PERIOD];
        assign wr_period_mode[p] = pif.ctrl_q[BIT_WR_PERIOD];
        assign quiesce_high[p]   = pif.ctrl_q[BIT_QUIESCE];
        assign ot_rd_en[p]       = pif.ot_rd_act;
        assign ot_wr_en[p]       = pif.ot_wr_act;

        // Applied QoS: override, live regulator or master pass-through
        assign out_arqos[p*QW +: QW] = qosovr_pick(port_qos_force_inputs[p], pif.ctrl_q[BIT_QV_RD],
            pif.rd_force_q[QW-1:0], live_arqos[p*QW +: QW], master_arqos[p*QW +: QW]);
        assign out_awqos[p*QW +: QW] = qosovr_pick(port_qos_force_inputs[p], pif.ctrl_q[BIT_QV_WR],
            pif.wr_force_q[QW-1:0], live_awqos[p*QW +: QW], master_awqos[p*QW +: QW]);

        // Read word selection for this port
        always_comb begin
            case (reg_off)
                OFF_RD_FORCE: rd_word[p] = pif.rd_force_q;
                OFF_WR_FORCE: rd_word[p] = pif.wr_force_q;
                OFF_CTRL:     rd_word[p] = pif.ctrl_q;
                default:      rd_word[p] = 32'h0000_0000;
            endcase
        end
    end

    // Read data and error are captured at the setup cycle
    always_comb begin
        nxt_rsp = rsp_ff;
        if (psel && !penable) begin
            nxt_rsp.rdata = (acc_ok && !pwrite) ? rd_word[port_idx] : 32'h0000_0000;
            nxt_rsp.err   = !acc_ok;
        end
    end

    // Response register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end

    assign prdata  = rsp_ff.rdata;
    assign pslverr = rsp_ff.err && pready;

    AST_FORCE_OVR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (port_qos_force_inputs[0] && !qv_rd_en[0]) |-> out_arqos[3:0] == g_port[0].pif.rd_force_q[3:0])
        else $error("read override not applied");
    AST_PASS: assert property (@(posedge core_clk) disable iff (!rst_n)
        !port_qos_force_inputs[1] |-> out_awqos[7:4] == master_awqos[7:4])
        else $error("write QoS not passed through");
    AST_SEC: assert property (@(posedge core_clk) disable iff (!rst_n)
        (psel && penable && pwrite && pprot[1] && !nonsec_allow) |-> !wr_go)
        else $error("non-secure write accepted");
    AST_COH_OT: assert property (@(posedge core_clk) disable iff (!rst_n)
        ot_rd_en[4:3] == 2'b00 && ot_wr_en[4:3] == 2'b00)
        else $error("coherent port OT enabled");
    AST_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
        prdata[31:22] == 10'h000) else $error("reserved bits nonzero");
    AST_LIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (psel && !penable && acc_ok && !pwrite && reg_off == OFF_RD_FORCE && port_idx == 3'h2)
        |=> prdata[11:8] == $past(live_arqos[11:8])) else $error("live read value wrong");
endmodule // qosovr_regs
`default_nettype wire

// [tb/qosovr_regs_tb.sv]
// Self-checking bench for the QoS override register bank, driven over APB.
// Assumes a zero-wait slave, ports 0..2 lightweight and ports 3..4 fully coherent.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module qosovr_regs_tb;
    import qosovr_pkg::*;
    // Stimulus and observed signals
    logic        core_clk = 1'b0, rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nonsec_allow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [2:0]  pprot = 3'h0;
    logic [4:0]  force_in = 5'h00, rd_idle = 5'h1f, wr_idle = 5'h1f;
    logic [19:0] m_ar = 20'h0, m_aw = 20'h0, l_ar = 20'h0, l_aw = 20'h0, out_arqos, out_awqos;
    logic [4:0]  qv_rd_en, qv_wr_en, rd_period_mode, wr_period_mode, quiesce_high, ot_rd_en, ot_wr_en;
    logic        pready, pslverr;
    // Scoreboard and register model
    logic [32:0] exp_q[$], exp_now;
    logic [3:0]  rf[5], wf[5], qe;
    logic [31:0] cm[5];
    int          err_total = 0, n_tests = 0, seed = 10;

    qosovr_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .nonsec_allow(nonsec_allow), .port_qos_force_inputs(force_in), .master_arqos(m_ar),
        .master_awqos(m_aw), .live_arqos(l_ar), .live_awqos(l_aw), .rd_idle(rd_idle), .wr_idle(wr_idle),
        .out_arqos(out_arqos), .out_awqos(out_awqos), .qv_rd_en(qv_rd_en), .qv_wr_en(qv_wr_en),
        .rd_period_mode(rd_period_mode), .wr_period_mode(wr_period_mode), .quiesce_high(quiesce_high),
        .ot_rd_en(ot_rd_en), .ot_wr_en(ot_wr_en));

    // Free-running 125 MHz clock
    always #4 core_clk = ~core_clk;

    function automatic logic [11:0] adr(input int p, input logic [3:0] o);
        return 12'(p * 16) | {8'h00, o};
    endfunction

    // Applied QoS worked out independently of the design
    function automatic logic [3:0] qx(input logic f, input logic en, input logic [3:0] ov,
                                      input logic [3:0] lv, input logic [3:0] ms);
        if (f && !en)
            return ov;
        if (f && ms == 4'h0)
            return lv;
        return ms;
    endfunction

    // One APB transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat, input logic [2:0] pr);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dat;
        pprot   <= pr;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] ex, input logic [2:0] pr);
        exp_q.push_back(ex);
        apb(1'b0, a, 32'h0, pr);
    endtask

    // Write with its expected error flag; write data reads back as zero
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [2:0] pr, input logic err);
        exp_q.push_back({err, 32'h0});
        apb(1'b1, a, dat, pr);
    endtask

    // Response watcher: one note off the queue per completed transfer
    always @(negedge core_clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, {pslverr, prdata}, 33'h0);
            end else begin
                exp_now = exp_q.pop_front();
                `CHK({pslverr, prdata}, exp_now)
            end
        end
    end

    task automatic chk_port(input int p);
        rd(adr(p, OFF_RD_FORCE), {21'h0, l_ar[4*p+:4], 4'h0, rf[p]}, 3'h0);
        rd(adr(p, OFF_WR_FORCE), {21'h0, l_aw[4*p+:4], 4'h0, wf[p]}, 3'h0);
        rd(adr(p, OFF_CTRL), {1'b0, cm[p]}, 3'h0);
    endtask

    task automatic wr_port(input int p);
        d = $random(seed);
        wr(adr(p, OFF_RD_FORCE), d, 3'h0, 1'b0);
        rf[p] = d[3:0];
        d = $random(seed);
        wr(adr(p, OFF_WR_FORCE), d, 3'h0, 1'b0);
        wf[p] = d[3:0];
        d = $random(seed);
        wr(adr(p, OFF_CTRL), d, 3'h0, 1'b0);
        cm[p] = d & ((p < 3) ? 32'h0031000f : 32'h00310003);
    endtask

    task automatic summarize();
        if (exp_q.size() != 0)
            err_total++;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge core_clk);
        err_total++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (7) @(posedge core_clk);
        l_ar  <= 20'($random(seed));
        l_aw  <= 20'($random(seed));
        @(posedge core_clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            rf[p] = 4'h0;
            wf[p] = 4'h0;
            cm[p] = 32'h0;
            chk_port(p);
        end
        for (int r = 0; r < 3; r++) begin
            for (int p = 0; p < 5; p++)
                wr_port(p);
            for (int p = 0; p < 5; p++)
                chk_port(p);
            @(negedge core_clk);
            for (int p = 0; p < 5; p++) begin
                `CHK({quiesce_high[p], rd_period_mode[p], wr_period_mode[p], qv_rd_en[p], qv_wr_en[p]},
                     {cm[p][21], cm[p][20], cm[p][16], cm[p][1], cm[p][0]})
                `CHK({ot_rd_en[p], ot_wr_en[p]}, {cm[p][3], cm[p][2]})
            end
            // Random force, master and live values against the applied QoS
            repeat (10) begin
                @(posedge core_clk);
                force_in <= 5'($random(seed));
                m_ar     <= 20'($random(seed)) & 20'($random(seed));
                m_aw     <= 20'($random(seed)) & 20'($random(seed));
                l_ar     <= 20'($random(seed));
                l_aw     <= 20'($random(seed));
                @(negedge core_clk);
                for (int p = 0; p < 5; p++) begin
                    qe = qx(force_in[p], cm[p][1], rf[p], l_ar[4*p+:4], m_ar[4*p+:4]);
                    `CHK(out_arqos[4*p+:4], qe)
                    qe = qx(force_in[p], cm[p][0], wf[p], l_aw[4*p+:4], m_aw[4*p+:4]);
                    `CHK(out_awqos[4*p+:4], qe)
                end
            end
        end
        // Non-secure accesses refused, then allowed by the permission input
        wr(adr(1, OFF_RD_FORCE), {28'h0, ~rf[1]}, 3'h2, 1'b1);
        rd(adr(1, OFF_RD_FORCE), {1'b1, 32'h0}, 3'h2);
        chk_port(1);
        @(posedge core_clk);
        nonsec_allow <= 1'b1;
        rf[1] = ~rf[1];
        wr(adr(1, OFF_RD_FORCE), {28'h0, rf[1]}, 3'h2, 1'b0);
        rd(adr(1, OFF_RD_FORCE), {21'h0, l_ar[7:4], 4'h0, rf[1]}, 3'h2);
        @(posedge core_clk);
        nonsec_allow <= 1'b0;
        // Unmapped address answers with an error and zero data
        wr(12'h050, 32'hffffffff, 3'h0, 1'b1);
        rd(12'h050, {1'b1, 32'h0}, 3'h0);
        rd(adr(0, 4'h2), {1'b1, 32'h0}, 3'h0);
        // Outstanding regulation change waits for an idle port
        @(posedge core_clk);
        rd_idle <= 5'h00;
        wr_idle <= 5'h00;
        d = cm[0] ^ 32'h0000000c;
        wr(adr(0, OFF_CTRL), d, 3'h0, 1'b0);
        repeat (3) @(negedge core_clk);
        `CHK({ot_rd_en[0], ot_wr_en[0]}, {cm[0][3], cm[0][2]})
        @(posedge core_clk);
        rd_idle <= 5'h1f;
        wr_idle <= 5'h1f;
        repeat (2) @(negedge core_clk);
        `CHK({ot_rd_en[0], ot_wr_en[0]}, {d[3], d[2]})
        repeat (4) @(posedge core_clk);
        summarize();
    end
endmodule // qosovr_regs_tb
`default_nettype wire
